//--- verilog/hub_reset_and_link_power_control.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// [RQ1] The link has an on, a sleep and a suspend power state and moves between them on request.
// [RQ2] Sleep entry completes under 10 us and sleep exit to on completes under 50 us.
// [RQ3] Suspend entry takes about 3 ms and exit takes about 2 ms from the start of resume.
// [RQ4] Resets come from power-on, the active-low chip reset pin and an upstream bus reset.
// [RQ5] After power is applied a timer holds internal reset for a fixed interval.
// [RQ6] While the chip reset pin is low the device sits in a minimal-current standby.
// [RQ7] Chip reset disables the phy and puts every differential pair in high impedance.
// [RQ8] Chip reset abandons every transaction at once and keeps no protocol state.
// [RQ9] Chip reset restores every internal register to its default.
// [RQ10] Chip reset stops the crystal oscillator and the pll.
// [RQ11] The system asserts chip reset only once supplies are at operating level.
// [RQ12] An upstream bus reset sets the device address to zero.
// [RQ13] An upstream bus reset returns the device to the unconfigured state.
// [RQ14] An upstream bus reset while suspended brings the device back to active.
// [RQ15] An upstream bus reset is never forwarded to downstream ports.
// [RQ16] The chip reset pin is active low and its rising edge releases the device.
// [RQ17] Leaving sleep or suspend always returns the link to the on state.
module hub_reset_and_link_power_control
    import hub_rst_pm_pkg::*;
#(
    parameter int unsigned SUSP_ENTRY_CYCLES = SUSP_ENTRY_CYC,
    parameter int unsigned SUSP_EXIT_CYCLES  = SUSP_EXIT_CYC,
    parameter int unsigned POR_HOLD_CYCLES   = POR_HOLD_CYC
) (
    input  wire logic              clk_sys_i,
    input  wire logic              reset_n_i,        // chip reset pin, low holds
    input  wire logic              por_n_i,          // power-good from supply monitor
    input  wire logic              bus_reset_i,      // upstream bus reset seen
    input  wire logic              sleep_req_i,      // lpm request to sleep
    input  wire logic              suspend_req_i,    // request to suspend
    input  wire logic              resume_i,         // resume signalling begun
    input  wire logic              set_addr_i,       // host assigns an address
    input  wire logic [6:0]        addr_i,
    input  wire logic              set_config_i,     // host configures device
    input  wire logic              xact_start_i,     // transaction begins
    input  wire logic              xact_end_i,       // transaction completes
    output var  logic              core_rst_n_o,     // internal reset, low active
    output var  logic              standby_o,
    output var  logic              phy_en_o,
    output var  logic              dp_oe_n_o,        // pairs tristated when high
    output var  logic              osc_en_o,
    output var  logic              pll_en_o,
    output var  logic [6:0]        dev_addr_o,
    output var  logic              configured_o,
    output var  logic              xact_busy_o,
    output var  logic              ds_reset_o,       // downstream reset, never from bus
    output var  logic [5:0]        link_state_o,
    output var  logic              link_active_o
);

    // ----------------------------------------------------------------
    // power-on hold timer
    // ----------------------------------------------------------------
    logic por_done;

    por_hold_timer #(
        .HOLD_CYC   (POR_HOLD_CYCLES)
    ) por_hold_timer_inst (
        .clk_sys_i  (clk_sys_i),
        .reset_n_i  (reset_n_i),
        .por_n_i    (por_n_i),
        .rst_done_o (por_done)       // RQ5
    );

    logic run;
    assign run = por_done;           // RQ4

    // ----------------------------------------------------------------
    // chip-level reset outputs
    // ----------------------------------------------------------------
    logic core_rst_n_r;
    logic core_rst_n_nxt;
    logic standby_r;
    logic standby_nxt;
    logic phy_en_r;
    logic phy_en_nxt;
    logic osc_en_r;
    logic osc_en_nxt;
    logic dp_oe_n_r;
    logic dp_oe_n_nxt;
    logic ds_reset_r;
    logic ds_reset_nxt;

    // released only after the pin rises and the timer finishes
    always_comb begin
        core_rst_n_nxt = run;        // RQ16
        standby_nxt    = 1'b0;
        phy_en_nxt     = run;        // RQ7
        osc_en_nxt     = 1'b1;
        dp_oe_n_nxt    = ~run;       // RQ7
        ds_reset_nxt   = ~run;       // RQ15
    end

    // pin low forces the reset values without any clock
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            core_rst_n_r <= 1'b0;    // RQ9
            standby_r    <= 1'b1;    // RQ6
            phy_en_r     <= 1'b0;    // RQ7
            osc_en_r     <= 1'b0;    // RQ10
            dp_oe_n_r    <= 1'b1;    // RQ7
            ds_reset_r   <= 1'b1;
        end else begin
            core_rst_n_r <= core_rst_n_nxt;
            standby_r    <= standby_nxt;
            phy_en_r     <= phy_en_nxt;
            osc_en_r     <= osc_en_nxt;
            dp_oe_n_r    <= dp_oe_n_nxt;
            ds_reset_r   <= ds_reset_nxt;
        end
    end

    // ----------------------------------------------------------------
    // usb device state: address, configuration, transactions
    // ----------------------------------------------------------------
    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] addr_nxt;
    logic              conf_r;
    logic              conf_nxt;
    logic              busy_r;
    logic              busy_nxt;

    always_comb begin
        addr_nxt = addr_r;
        conf_nxt = conf_r;
        busy_nxt = busy_r;
        if (!run) begin
            addr_nxt = ADDR_RST;
            conf_nxt = CONF_RST;
            busy_nxt = 1'b0;
        end else if (bus_reset_i) begin
            addr_nxt = ADDR_RST;     // RQ12
            conf_nxt = CONF_RST;     // RQ13
            busy_nxt = 1'b0;
        end else begin
            if (set_addr_i) begin
                addr_nxt = addr_i;
            end
            if (set_config_i) begin
                conf_nxt = 1'b1;
            end
            if (xact_start_i) begin
                busy_nxt = 1'b1;
            end else if (xact_end_i) begin
                busy_nxt = 1'b0;
            end
        end
    end

    // transactions dropped at once on the pin
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            addr_r <= ADDR_RST;
            conf_r <= CONF_RST;
            busy_r <= 1'b0;          // RQ8
        end else begin
            addr_r <= addr_nxt;
            conf_r <= conf_nxt;
            busy_r <= busy_nxt;
        end
    end

    // ----------------------------------------------------------------
    // link power state machine
    // ----------------------------------------------------------------
    link_state_t      st_r;
    link_state_t      st_nxt;
    logic [CNT_W-1:0] tmr_r;
    logic [CNT_W-1:0] tmr_nxt;
    logic [CNT_W-1:0] wake_len_r;
    logic [CNT_W-1:0] wake_len_nxt;

    always_comb begin
        st_nxt       = st_r;
        tmr_nxt      = tmr_r + 1'b1;
        wake_len_nxt = wake_len_r;
        if (!run) begin
            st_nxt  = link_on_state;
            tmr_nxt = CNT_ZERO;
        end else if (bus_reset_i) begin
            st_nxt  = link_on_state; // RQ14
            tmr_nxt = CNT_ZERO;
        end else begin
            case (st_r)
                link_on_state: begin
                    tmr_nxt = CNT_ZERO;
                    if (suspend_req_i) begin
                        st_nxt = link_susp_entry;      // RQ1
                    end else if (sleep_req_i) begin
                        st_nxt = link_sleep_entry;     // RQ1
                    end
                end
                link_sleep_entry: begin
                    if (tmr_r >= CNT_W'(SLEEP_ENTRY_CYC - 1)) begin
                        st_nxt  = link_sleep_state;    // RQ2
                        tmr_nxt = CNT_ZERO;
                    end
                end
                link_susp_entry: begin
                    if (tmr_r >= CNT_W'(SUSP_ENTRY_CYCLES - 1)) begin
                        st_nxt  = link_suspend_state;  // RQ3
                        tmr_nxt = CNT_ZERO;
                    end
                end
                link_sleep_state: begin
                    tmr_nxt = CNT_ZERO;
                    if (resume_i) begin
                        st_nxt       = link_wake;
                        wake_len_nxt = CNT_W'(SLEEP_EXIT_CYC - 1);   // RQ2
                    end
                end
                link_suspend_state: begin
                    tmr_nxt = CNT_ZERO;
                    if (resume_i) begin
                        st_nxt       = link_wake;
                        wake_len_nxt = CNT_W'(SUSP_EXIT_CYCLES - 1); // RQ3
                    end
                end
                link_wake: begin
                    if (tmr_r >= wake_len_r) begin
                        st_nxt  = link_on_state;       // RQ17
                        tmr_nxt = CNT_ZERO;
                    end
                end
                default: begin
                    st_nxt  = link_on_state;
                    tmr_nxt = CNT_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r       <= link_on_state;
            tmr_r      <= CNT_ZERO;
            wake_len_r <= CNT_ZERO;
        end else begin
            st_r       <= st_nxt;
            tmr_r      <= tmr_nxt;
            wake_len_r <= wake_len_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all straight from flops
    // ----------------------------------------------------------------
    assign core_rst_n_o  = core_rst_n_r;
    assign standby_o     = standby_r;
    assign phy_en_o      = phy_en_r;
    assign dp_oe_n_o     = dp_oe_n_r;  // RQ7
    assign osc_en_o      = osc_en_r;
    assign pll_en_o      = osc_en_r;   // RQ10
    assign dev_addr_o    = addr_r;
    assign configured_o  = conf_r;
    assign xact_busy_o   = busy_r;
    assign ds_reset_o    = ds_reset_r;     // RQ15
    assign link_state_o  = st_r;
    assign link_active_o = core_rst_n_r;

endmodule

`default_nettype wire

//--- inc/hub_rst_pm_pkg.sv
package hub_rst_pm_pkg;

    // ----------------------------------------------------------------
    // clock and link timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS      = 10;
    localparam int unsigned SLEEP_ENTRY_NS     = 10000;    // 10 us, upper bound
    localparam int unsigned SLEEP_EXIT_NS      = 50000;    // 50 us, upper bound
    localparam int unsigned SUSP_ENTRY_US      = 3000;     // ~3 ms
    localparam int unsigned SUSP_EXIT_US       = 2000;     // ~2 ms from resume start
    localparam int unsigned POR_HOLD_US        = 100;      // power-on hold interval

    // longest times round down, kept below the bound by one cycle
    localparam int unsigned SLEEP_ENTRY_CYC    = SLEEP_ENTRY_NS / CLK_PERIOD_NS - 1;
    localparam int unsigned SLEEP_EXIT_CYC     = SLEEP_EXIT_NS / CLK_PERIOD_NS - 1;
    localparam int unsigned SUSP_ENTRY_CYC     = SUSP_ENTRY_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned SUSP_EXIT_CYC      = SUSP_EXIT_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned POR_HOLD_CYC       = POR_HOLD_US * 1000 / CLK_PERIOD_NS;

    localparam int unsigned CNT_W              = 20;
    localparam int unsigned ADDR_W             = 7;
    localparam logic [6:0]  ADDR_RST           = 7'h00;
    localparam logic        CONF_RST           = 1'b0;
    localparam logic [CNT_W-1:0] CNT_ZERO      = 20'h00000;

    // ----------------------------------------------------------------
    // link power states
    // ----------------------------------------------------------------
    typedef enum logic [5:0] {
        link_on_state        = 6'b000001,
        link_sleep_entry     = 6'b000010,
        link_sleep_state     = 6'b000100,
        link_susp_entry      = 6'b001000,
        link_suspend_state   = 6'b010000,
        link_wake            = 6'b100000
    } link_state_t;

endpackage

//--- verilog/por_hold_timer.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// holds internal reset for a fixed count after power-up
// ----------------------------------------------------------------
module por_hold_timer
    import hub_rst_pm_pkg::*;
#(
    parameter int unsigned HOLD_CYC = POR_HOLD_CYC
) (
    input  wire logic clk_sys_i,
    input  wire logic reset_n_i,
    input  wire logic por_n_i,
    output var  logic rst_done_o
);

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             done_r;
    logic             done_nxt;

    // count up to the hold figure, then release
    always_comb begin
        cnt_nxt  = cnt_r;
        done_nxt = done_r;
        if (!por_n_i) begin
            cnt_nxt  = CNT_ZERO;
            done_nxt = 1'b0;
        end else if (!done_r) begin
            if (cnt_r >= CNT_W'(HOLD_CYC)) begin
                done_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_r  <= CNT_ZERO;
            done_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign rst_done_o = done_r;

endmodule

`default_nettype wire

//--- testbench/usb_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------
// upstream host: bus reset, address, resume
// ------------------------------------------
module usb_host_model (
    input  wire logic       clk_sys_i,
    output var  logic       bus_reset_o,
    output var  logic       resume_o,
    output var  logic       set_addr_o,
    output var  logic [6:0] addr_o,
    output var  logic       set_config_o
);
    // idle values at time zero
    initial begin
        bus_reset_o = 1'b0;
        resume_o = 1'b0;
        set_addr_o = 1'b0;
        addr_o = 7'h55;
        set_config_o = 1'b0;
    end
    // bus reset held for n cycles
    task automatic bus_reset(input int n);
        @(negedge clk_sys_i);
        bus_reset_o = 1'b1;
        repeat (n) @(negedge clk_sys_i);
        bus_reset_o = 1'b0;
    endtask
    // address load, bus shows inverse when idle
    task automatic assign_addr(input logic [6:0] a);
        @(negedge clk_sys_i);
        addr_o = a;
        set_addr_o = 1'b1;
        @(negedge clk_sys_i);
        set_addr_o = 1'b0;
        addr_o = ~a;
    endtask
    // configuration request
    task automatic configure();
        @(negedge clk_sys_i);
        set_config_o = 1'b1;
        @(negedge clk_sys_i);
        set_config_o = 1'b0;
    endtask
    // start of resume signalling
    task automatic resume();
        @(negedge clk_sys_i);
        resume_o = 1'b1;
        @(negedge clk_sys_i);
        resume_o = 1'b0;
    endtask
endmodule

`default_nettype wire

//--- testbench/hub_rst_pm_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module hub_rst_pm_checker
    import hub_rst_pm_pkg::*;
#(
    parameter int unsigned SUSP_ENTRY_CYCLES = 20,
    parameter int unsigned POR_HOLD_CYCLES   = 8
) (
    input wire logic       clk_sys_i,
    input wire logic       reset_n_i,
    input wire logic       por_n_i,
    input wire logic       bus_reset_i,
    input wire logic       sleep_req_i,
    input wire logic       suspend_req_i,
    input wire logic       resume_i,
    input wire logic       core_rst_n_o,
    input wire logic       standby_o,
    input wire logic       phy_en_o,
    input wire logic       dp_oe_n_o,
    input wire logic       osc_en_o,
    input wire logic       pll_en_o,
    input wire logic [6:0] dev_addr_o,
    input wire logic       configured_o,
    input wire logic       xact_busy_o,
    input wire logic       ds_reset_o,
    input wire logic [5:0] link_state_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    // -------------------------------
    // state age and power-up counters
    // -------------------------------
    logic [19:0] cnt_r, cnt_nxt, hold_r, hold_nxt;
    logic [5:0]  prev_r;
    always_comb begin
        cnt_nxt = (link_state_o == prev_r) ? cnt_r + 20'h00001 : 20'h00000;
        hold_nxt = por_n_i ? hold_r + 20'h00001 : 20'h00000;
    end
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_r <= 20'h00000;
            hold_r <= 20'h00000;
            prev_r <= link_on_state;
        end else begin
            cnt_r <= cnt_nxt;
            hold_r <= hold_nxt;
            prev_r <= link_state_o;
        end
    end
    sequence sleep_taken;
        core_rst_n_o && link_state_o == link_on_state && sleep_req_i
            && !suspend_req_i && !bus_reset_i;
    endsequence
    sequence wake_ends;
        link_state_o == link_wake ##1 link_state_o != link_wake;
    endsequence
    chk_reset_quiet: assert property (disable iff (1'b0) !reset_n_i |->
        standby_o && !phy_en_o && !osc_en_o && !pll_en_o && !core_rst_n_o
        && dev_addr_o == 7'h00 && !configured_o && !xact_busy_o)
        else $error("outputs not quiet in chip reset");
    chk_pair_tristate: assert property (dp_oe_n_o == !phy_en_o)
        else $error("pair enable disagrees with phy enable");
    chk_bus_rst_clear: assert property (core_rst_n_o && bus_reset_i |=>
        dev_addr_o == 7'h00 && !configured_o && link_state_o == link_on_state)
        else $error("bus reset did not clear address, config or state");
    chk_no_forward: assert property (ds_reset_o == !core_rst_n_o)
        else $error("downstream reset not tied to core reset");
    chk_sleep_go: assert property (sleep_taken |=> link_state_o == link_sleep_entry)
        else $error("sleep request not taken");
    chk_entry_age: assert property (link_state_o == link_sleep_entry |-> cnt_nxt < 20'd999)
        else $error("sleep entry too long");
    chk_wake_age: assert property (link_state_o == link_wake |-> cnt_nxt < 20'd4999)
        else $error("wake too long");
    chk_susp_age: assert property (link_state_o == link_susp_entry |->
        cnt_nxt < SUSP_ENTRY_CYCLES)
        else $error("suspend entry too long");
    chk_resume_wake: assert property (core_rst_n_o && link_state_o == link_suspend_state
        && resume_i && !bus_reset_i |=> link_state_o == link_wake)
        else $error("resume from suspend not taken");
    chk_exit_on: assert property (wake_ends |-> link_state_o == link_on_state)
        else $error("wake did not end in on state");
    chk_por_hold: assert property ($rose(core_rst_n_o) |-> hold_r >= POR_HOLD_CYCLES)
        else $error("internal reset released early");
endmodule

bind hub_reset_and_link_power_control hub_rst_pm_checker #(
    .SUSP_ENTRY_CYCLES(SUSP_ENTRY_CYCLES),
    .POR_HOLD_CYCLES  (POR_HOLD_CYCLES)
) hub_rst_pm_checker_inst (
    .clk_sys_i, .reset_n_i, .por_n_i, .bus_reset_i, .sleep_req_i,
    .suspend_req_i, .resume_i, .core_rst_n_o, .standby_o, .phy_en_o,
    .dp_oe_n_o, .osc_en_o, .pll_en_o, .dev_addr_o, .configured_o,
    .xact_busy_o, .ds_reset_o, .link_state_o
);

`default_nettype wire

//--- testbench/hub_reset_and_link_power_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module hub_reset_and_link_power_control_tb_top;
    import hub_rst_pm_pkg::*;
    localparam int unsigned SE = 20;
    localparam int unsigned SX = 10;
    localparam int unsigned PH = 8;
    // supplies up when chip reset asserts
    logic       clk_sys_i = 0, reset_n_i = 1, por_n_i = 1;
    logic       sleep_req_i = 0, suspend_req_i = 0, xact_start_i = 0, xact_end_i = 0;
    logic       bus_reset_i, resume_i, set_addr_i, set_config_i;
    logic [6:0] addr_i, dev_addr_o;
    logic       core_rst_n_o, standby_o, phy_en_o, dp_oe_n_o, osc_en_o, pll_en_o;
    logic       configured_o, xact_busy_o, ds_reset_o, link_active_o;
    logic [5:0] link_state_o;
    int         fails = 0, checked = 0, cyc = 0;

    initial forever #5 clk_sys_i = ~clk_sys_i;

    usb_host_model usb_host_model_inst (.clk_sys_i, .bus_reset_o(bus_reset_i),
        .resume_o(resume_i), .set_addr_o(set_addr_i), .addr_o(addr_i),
        .set_config_o(set_config_i));

    hub_reset_and_link_power_control #(.SUSP_ENTRY_CYCLES(SE), .SUSP_EXIT_CYCLES(SX),
        .POR_HOLD_CYCLES(PH)) hub_reset_and_link_power_control_inst (.clk_sys_i,
        .reset_n_i, .por_n_i, .bus_reset_i, .sleep_req_i, .suspend_req_i, .resume_i,
        .set_addr_i, .addr_i, .set_config_i, .xact_start_i, .xact_end_i, .core_rst_n_o,
        .standby_o, .phy_en_o, .dp_oe_n_o, .osc_en_o, .pll_en_o, .dev_addr_o,
        .configured_o, .xact_busy_o, .ds_reset_o, .link_state_o, .link_active_o);

    // ------------------
    // shared checks
    // ------------------
    task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wait_st(input logic [5:0] s, input int lim, output int n);
        n = 0;
        while (link_state_o !== s && n < lim) begin
            @(negedge clk_sys_i);
            n++;
        end
    endtask
    task automatic wait_core(output int n);
        n = 0;
        while (core_rst_n_o !== 1'b1 && n < 100) begin
            @(negedge clk_sys_i);
            n++;
        end
    endtask
    task automatic test_done;
        if (fails == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ------------------
    // scenarios
    // ------------------
    task automatic t_power_up;
        int n;
        chk("standby", {standby_o, dp_oe_n_o, osc_en_o, pll_en_o}, 4'hc);
        @(negedge clk_sys_i);
        reset_n_i = 1'b1;
        wait_core(n);
        chk("hold_len", n >= PH && n < 20, 1'b1);
        chk("running", {standby_o, osc_en_o, phy_en_o, ds_reset_o, link_active_o, dp_oe_n_o},
            6'h1a);
        chk("link_on", link_state_o, link_on_state);
    endtask
    task automatic t_bus_reset;
        usb_host_model_inst.assign_addr(7'h2a);
        usb_host_model_inst.configure();
        chk("addr_set", {configured_o, dev_addr_o}, 8'haa);
        usb_host_model_inst.bus_reset(3);
        chk("addr_zero", dev_addr_o, ADDR_RST);
        chk("unconf", configured_o, CONF_RST);
        chk("ds_keep", {ds_reset_o, core_rst_n_o}, 2'h1);
    endtask
    task automatic t_sleep;
        int n;
        @(negedge clk_sys_i);
        sleep_req_i = 1'b1;
        @(negedge clk_sys_i);
        sleep_req_i = 1'b0;
        chk("sl_entry", link_state_o, link_sleep_entry);
        wait_st(link_sleep_state, 2000, n);
        chk("sl_in", link_state_o === link_sleep_state && n < 1000, 1'b1);
        usb_host_model_inst.resume();
        wait_st(link_on_state, 6000, n);
        chk("sl_out", link_state_o === link_on_state && n < 5000, 1'b1);
    endtask
    task automatic t_suspend;
        int n;
        for (int k = 0; k < 2; k++) begin
            @(negedge clk_sys_i);
            {suspend_req_i, sleep_req_i} = 2'b11;
            @(negedge clk_sys_i);
            {suspend_req_i, sleep_req_i} = 2'b00;
            chk("su_entry", link_state_o, link_susp_entry);
            wait_st(link_suspend_state, 100, n);
            chk("su_in", link_state_o === link_suspend_state && n == SE, 1'b1);
            if (k == 0) begin
                usb_host_model_inst.bus_reset(1);
                chk("su_bus_rst", link_state_o, link_on_state);
            end else begin
                usb_host_model_inst.resume();
                wait_st(link_on_state, 100, n);
                chk("su_out", link_state_o === link_on_state && n <= SX, 1'b1);
            end
        end
    endtask
    task automatic t_chip_reset;
        int n;
        usb_host_model_inst.assign_addr(7'h13);
        usb_host_model_inst.configure();
        @(negedge clk_sys_i);
        xact_start_i = 1'b1;
        @(negedge clk_sys_i);
        {xact_start_i, xact_end_i} = 2'b01;
        chk("busy_set", xact_busy_o, 1'b1);
        @(negedge clk_sys_i);
        xact_end_i = 1'b0;
        chk("busy_end", xact_busy_o, 1'b0);
        @(negedge clk_sys_i);
        xact_start_i = 1'b1;
        sleep_req_i = 1'b1;
        @(negedge clk_sys_i);
        {xact_start_i, sleep_req_i} = 2'b00;
        chk("busy", xact_busy_o, 1'b1);
        @(negedge clk_sys_i);
        reset_n_i = 1'b0;
        #1;
        chk("rst_outs", {core_rst_n_o, phy_en_o, xact_busy_o, pll_en_o}, 4'h0);
        chk("rst_regs", {configured_o, dev_addr_o}, 8'h00);
        chk("rst_link", link_state_o, link_on_state);
        t_power_up();
        @(negedge clk_sys_i);
        por_n_i = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        chk("por_low", core_rst_n_o, 1'b0);
        por_n_i = 1'b1;
        wait_core(n);
        chk("por_hold", n >= PH && n < 20, 1'b1);
    endtask

    // hang guard
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc > 20000) begin
            fails++;
            test_done();
        end
    end
    initial begin
        // pin falls off the clock edge so the async reset fires at once
        #1 reset_n_i = 1'b0;
        repeat (10) @(posedge clk_sys_i);
        t_power_up();
        t_bus_reset();
        t_sleep();
        t_suspend();
        t_chip_reset();
        test_done();
    end
endmodule

`default_nettype wire
